/* common/lpzd_cfg.svh */
// Constants for the linear position zero and direction logic.
// Assumes a 250 MHz system clock; included by package and design files.
`ifndef LPZD_CFG_SVH
`define LPZD_CFG_SVH

`define LPZD_POS_WIDTH      20
`define LPZD_POS_MAX        20'hFFFFF
`define LPZD_POS_RESET      20'h00000
`define LPZD_CLK_MHZ        250
`define LPZD_ZERO_MIN_US    100
`define LPZD_ZERO_CYCLES    ((`LPZD_ZERO_MIN_US) * (`LPZD_CLK_MHZ))
`define LPZD_QUAL_WIDTH     15

`endif

/* common/lpzd_pkg.sv */
// Types for the linear position zero and direction logic.
// Assumes lpzd_cfg.svh is on the include path.
`include "lpzd_cfg.svh"
package lpzd_pkg;
	typedef logic [`LPZD_POS_WIDTH-1:0] lpzd_pos_type;
	typedef logic [`LPZD_QUAL_WIDTH-1:0] lpzd_qual_type;
	typedef enum logic [2:0]
	{
		LPZD_IDLE  = 3'b001,
		LPZD_QUAL  = 3'b010,
		LPZD_DONE  = 3'b100
	} lpzd_zst_type;
endpackage

/* rtl/lpzd_zero_qual.sv */
// Zero-request input stage: two-flop synchroniser ahead of the qualifier.
// Assumes the request pin is a level from an external controller.
module lpzd_zero_qual
(
	input  wire logic i_sys_clk,
	input  wire logic i_arst_n,
	input  wire logic i_zero_req,
	output logic      o_zero_sync
);
	logic [1:0] sync_q;
	logic [1:0] sync_d;

	// Shift the request through two stages; only the second stage leaves
	always_comb
	begin
		sync_d = {sync_q[0], i_zero_req};
	end

	// Register both stages; reset to the resting low level
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			sync_q <= 2'h0;
		end
		else
		begin
			sync_q <= sync_d;
		end
	end

	assign o_zero_sync = sync_q[1];
endmodule // lpzd_zero_qual

/* rtl/lpzd_position.sv */
// Position counter of the linear encoder with zeroing and direction select.
// Assumes movement steps arrive as one-cycle pulses synchronous to i_sys_clk.
//
// Notes on behaviour
// RL1: Controller holds zero request high at least 100 us, then returns low.
// RL2: An accepted zero request loads the position count with zero.
// RL3: Controller zeroes only while the sensor stands still.
// RL4: Controller sets direction first, then zeroes; re-zero after any direction change.
// RL5: Direction low: standard-direction travel increases the count.
// RL6: Direction high: reverse-direction travel increases the count.
// RL7: Unused zero and direction inputs are tied low by the controller.
// RL8: Position is an unsigned count of at most 20 bits, max 1048575.
// RL9: Position is a count of resolution steps; distance is count times step.
// RL10: Zero request is synchronised, qualified by minimum high time, acted on once.
`include "lpzd_cfg.svh"
module lpzd_position
#(
	parameter int unsigned ZERO_CYCLES = `LPZD_ZERO_CYCLES
)
(
	input  wire logic          i_sys_clk,
	input  wire logic          i_arst_n,
	input  wire logic          i_zero_req,
	input  wire logic          i_dir_rev,
	input  wire logic          i_step_fwd,
	input  wire logic          i_step_bwd,
	output lpzd_pkg::lpzd_pos_type o_position,
	output logic               o_zero_done
);
	import lpzd_pkg::*;

	// Qualifying run ends here; the request must still be high at this count
	localparam lpzd_qual_type QUAL_LAST = lpzd_qual_type'(ZERO_CYCLES - 1);

	// Codes of the travel decode
	localparam logic [1:0] MOVE_NONE = 2'h0;
	localparam logic [1:0] MOVE_UP   = 2'h1;
	localparam logic [1:0] MOVE_DOWN = 2'h2;

	// Qualifier state, position state and the travel decode
	logic          zero_sync;
	logic [1:0]    move;
	lpzd_zst_type  zst_q;
	lpzd_zst_type  zst_d;
	lpzd_qual_type qual_cnt_q;
	lpzd_qual_type qual_cnt_d;
	logic          zero_pulse_q;
	logic          zero_pulse_d;
	lpzd_pos_type  pos_q;
	lpzd_pos_type  pos_d;
	logic          done_q;
	logic          done_d;

	// Count sense of one sample of the step pins; both or neither is no move
	function automatic logic [1:0] move_decode
	(
		input logic dir_rev,
		input logic step_fwd,
		input logic step_bwd
	);
		logic [1:0] sense;
		unique case ({step_fwd, step_bwd})
			2'h2:
			begin
				sense = dir_rev ? MOVE_DOWN : MOVE_UP; // RL5 RL6
			end
			2'h1:
			begin
				sense = dir_rev ? MOVE_UP : MOVE_DOWN; // RL5 RL6
			end
			default:
			begin
				sense = MOVE_NONE;
			end
		endcase
		return sense;
	endfunction

	// Saturating one-step move; the scale is absolute, so the count never wraps
	function automatic lpzd_pos_type count_step
	(
		input lpzd_pos_type count,
		input logic [1:0]   move_code
	);
		lpzd_pos_type result;
		result = count;
		unique case (move_code)
			MOVE_UP:
			begin
				if (count != `LPZD_POS_MAX)
				begin
					result = count + lpzd_pos_type'(1); // RL8 RL9
				end
			end
			MOVE_DOWN:
			begin
				if (count != `LPZD_POS_RESET)
				begin
					result = count - lpzd_pos_type'(1); // RL8 RL9
				end
			end
			default:
			begin
				result = count;
			end
		endcase
		return result;
	endfunction

	// Two-flop synchroniser for the zero request pin
	lpzd_zero_qual u_zero_qual (
		.i_sys_clk   (i_sys_clk),
		.i_arst_n    (i_arst_n),
		.i_zero_req  (i_zero_req),
		.o_zero_sync (zero_sync)
	);

	// Map travel to count sense through the direction input
	always_comb
	begin
		move = move_decode(i_dir_rev, i_step_fwd, i_step_bwd); // RL5 RL6
	end

	// Count continuous high time, fire once, then wait for release
	// Holding high longer gives one zero only; a new request needs a low sample
	always_comb
	begin
		zst_d        = zst_q;
		qual_cnt_d   = qual_cnt_q;
		zero_pulse_d = 1'b0;
		unique case (zst_q)
			LPZD_IDLE:
			begin
				qual_cnt_d = '0;
				if (zero_sync)
				begin
					zst_d = LPZD_QUAL;
				end
			end
			LPZD_QUAL:
			begin
				if (!zero_sync)
				begin
					zst_d = LPZD_IDLE; // Too short, dropped
				end
				else if (qual_cnt_q == QUAL_LAST)
				begin
					zero_pulse_d = 1'b1; // RL10
					zst_d        = LPZD_DONE;
				end
				else
				begin
					qual_cnt_d = qual_cnt_q + lpzd_qual_type'(1); // RL10
				end
			end
			LPZD_DONE:
			begin
				if (!zero_sync)
				begin
					zst_d = LPZD_IDLE; // RL10
				end
			end
			default:
			begin
				zst_d = LPZD_IDLE; // Illegal one-hot code recovers to idle
			end
		endcase
	end

	// Register the qualifier state, run counter and zero pulse
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			zst_q        <= LPZD_IDLE;
			qual_cnt_q   <= '0;
			zero_pulse_q <= 1'b0;
		end
		else
		begin
			zst_q        <= zst_d;
			qual_cnt_q   <= qual_cnt_d;
			zero_pulse_q <= zero_pulse_d;
		end
	end

	// Next position in step units; zeroing wins over a step in the same cycle
	// A step dropped there is harmless, since the controller zeroes at rest
	always_comb
	begin
		pos_d  = pos_q;
		done_d = 1'b0;
		if (zero_pulse_q)
		begin
			pos_d  = `LPZD_POS_RESET; // RL2
			done_d = 1'b1;
		end
		else
		begin
			pos_d = count_step(pos_q, move); // RL8 RL9
		end
	end

	// Register position and the one-cycle zero acknowledge
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			pos_q  <= `LPZD_POS_RESET;
			done_q <= 1'b0;
		end
		else
		begin
			pos_q  <= pos_d;
			done_q <= done_d;
		end
	end

	// Both outputs come straight from their registers
	assign o_position  = pos_q;
	assign o_zero_done = done_q;
endmodule // lpzd_position

/* tb/lpzd_position_sva.sv */
// Checker for lpzd_position, bound below.
// Expects ZERO_CYCLES equal to the bound instance.
module lpzd_position_sva
#(parameter int unsigned ZERO_CYCLES = 4)
(
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_zero_req,
	input wire logic i_dir_rev,
	input wire logic i_step_fwd,
	input wire logic i_step_bwd,
	input lpzd_pkg::lpzd_pos_type o_position,
	input wire logic o_zero_done
);
	timeunit 1ns;
	timeprecision 1ps;
	import lpzd_pkg::*;
	int run_q;
	logic fired_q;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	// Request run length, and whether this request already zeroed
	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			run_q <= 0;
			fired_q <= 1'b0;
		end
		else
		begin
			run_q <= i_zero_req ? run_q + 1 : 0;
			fired_q <= i_zero_req && (fired_q || o_zero_done);
		end
	end
	zero_load_a: assert property (o_zero_done |-> o_position == '0)
		else $error("zero not loaded");
	fwd_up_a: assert property ((i_step_fwd && !i_step_bwd && !i_dir_rev && o_position != '1) ##1 !o_zero_done
		|-> o_position == $past(o_position) + 20'h1) else $error("forward step lost");
	rev_up_a: assert property ((i_step_bwd && !i_step_fwd && i_dir_rev && o_position != '1) ##1 !o_zero_done
		|-> o_position == $past(o_position) + 20'h1) else $error("reversed step lost");
	down_step_a: assert property ((i_step_bwd && !i_step_fwd && !i_dir_rev && o_position != '0)
		##1 !o_zero_done |-> o_position == $past(o_position) - 20'h1) else $error("backward step lost");
	count_floor_a: assert property ((o_position == '0 && i_step_bwd && !i_step_fwd && !i_dir_rev) |=> o_position == '0)
		else $error("count went below zero");
	zero_qual_a: assert property (o_zero_done |-> run_q >= ZERO_CYCLES)
		else $error("zero on short request");
	one_zero_a: assert property (o_zero_done |-> !fired_q)
		else $error("second zero in one request");
	done_once_a: assert property (o_zero_done |=> !o_zero_done)
		else $error("zero acknowledge too long");
	zero_c: cover property (o_zero_done);
	both_c: cover property (i_step_fwd && i_step_bwd);
	rev_c: cover property (i_dir_rev && i_step_bwd);
	floor_c: cover property (o_position == '0 && i_step_bwd);
endmodule // lpzd_position_sva
bind lpzd_position lpzd_position_sva #(.ZERO_CYCLES(ZERO_CYCLES)) u_sva (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
	.i_zero_req(i_zero_req), .i_dir_rev(i_dir_rev), .i_step_fwd(i_step_fwd), .i_step_bwd(i_step_bwd),
	.o_position(o_position), .o_zero_done(o_zero_done));

/* tb/lpzd_ctrl_model.sv */
// Controller model driving zero request and direction.
// Drives on falling edges of the system clock.
module lpzd_ctrl_model
(
	input wire logic i_sys_clk,
	output logic o_zero_req,
	output logic o_dir_rev
);
	timeunit 1ns;
	timeprecision 1ps;
	// Both inputs rest low
	initial o_zero_req = 1'b0;
	initial o_dir_rev = 1'b0;
	// Request held n cycles while no steps run
	task automatic zero(input int n);
		@(negedge i_sys_clk) o_zero_req = 1'b1;
		repeat (n) @(negedge i_sys_clk);
		o_zero_req = 1'b0;
	endtask
	// Direction set before the zero that follows
	task automatic dir(input logic d);
		@(negedge i_sys_clk) o_dir_rev = d;
	endtask
endmodule // lpzd_ctrl_model

/* tb/tb_linear_position_zero_direction.sv */
// Bench for lpzd_position with a controller model.
// Uses ZERO_CYCLES of 4 and drives on falling edges.
module tb_linear_position_zero_direction;
	timeunit 1ns;
	timeprecision 1ps;
	import lpzd_pkg::*;
	localparam int unsigned ZC = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic zr, dr;
	logic sf = 1'b0;
	logic sb = 1'b0;
	lpzd_pos_type pos;
	logic zd;
	int done_n = 0;
	int miscompares = 0;
	int samples_checked = 0;
	// Clock of 4 ns period
	initial forever #2 clk = ~clk;
	lpzd_ctrl_model ctl (.i_sys_clk(clk), .o_zero_req(zr), .o_dir_rev(dr));
	lpzd_position #(.ZERO_CYCLES(ZC)) DUT (.i_sys_clk(clk), .i_arst_n(rst_n), .i_zero_req(zr), .i_dir_rev(dr),
		.i_step_fwd(sf), .i_step_bwd(sb), .o_position(pos), .o_zero_done(zd));
	// Count zero acknowledges at falling edges, where the registered pulse is settled
	always @(negedge clk)
		if (zd === 1'b1)
			done_n++;
	task automatic chk(input lpzd_pos_type s, input lpzd_pos_type e);
		samples_checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("MISMATCH %0t position %0h expected %0h", $time, s, e);
		end
	endtask
	task automatic step(input logic f, input logic b, input int n);
		repeat (n) @(negedge clk) {sf, sb} = {f, b};
		@(negedge clk) {sf, sb} = 2'b00;
	endtask
	task automatic t_count;
		step(1'b1, 1'b0, 5);
		chk(pos, 20'h00005);
		step(1'b0, 1'b1, 1);
		chk(pos, 20'h00004);
		step(1'b1, 1'b1, 2);
		chk(pos, 20'h00004);
	endtask
	task automatic t_zero;
		ctl.zero(2);
		repeat (8) @(negedge clk);
		chk(pos, 20'h00004);
		chk(lpzd_pos_type'(done_n), 20'h00000);
		ctl.zero(ZC + 12);
		chk(pos, 20'h00000);
		chk(lpzd_pos_type'(done_n), 20'h00001);
	endtask
	task automatic t_floor;
		step(1'b0, 1'b1, 2);
		chk(pos, 20'h00000);
	endtask
	task automatic t_reverse;
		ctl.dir(1'b1);
		ctl.zero(ZC + 12);
		step(1'b0, 1'b1, 3);
		chk(pos, 20'h00003);
		step(1'b1, 1'b0, 1);
		chk(pos, 20'h00002);
		step(1'b1, 1'b0, 3);
		chk(pos, 20'h00000);
		chk(lpzd_pos_type'(done_n), 20'h00002);
	endtask
	task automatic t_reset;
		ctl.dir(1'b0);
		ctl.zero(ZC + 12);
		step(1'b1, 1'b0, 3);
		chk(pos, 20'h00003);
		@(negedge clk) rst_n = 1'b0;
		@(negedge clk) rst_n = 1'b1;
		chk(pos, 20'h00000);
		step(1'b1, 1'b0, 1);
		chk(pos, 20'h00001);
		chk(lpzd_pos_type'(done_n), 20'h00003);
	endtask
	task automatic print_verdict;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Reset for 3 cycles, then the scenarios
	initial
	begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		t_count;
		t_zero;
		t_floor;
		t_reverse;
		t_reset;
		print_verdict;
	end
endmodule // tb_linear_position_zero_direction
